// ===== verilog/comparator_mode_ctrl_regs.sv
`include "cmp_cfg.svh"

// Overview of operation
// - Control bit 6 is read-only and shows the live comparator 1 output.
// - Control bit 5 sets on each rising comparator edge while bit 7 is set, cleared by writing zero.
// - Control bit 4 sets on each falling comparator edge while bit 7 is set, cleared by writing zero.
// - Control bits 3:2 drive positive hysteresis: off, 5, 10 or 20 mV.
// - Control bits 1:0 drive negative hysteresis: off, 5, 10 or 20 mV.
// - Mode bit 5 enables the rising-edge interrupt request.
// - Mode bit 4 enables the falling-edge interrupt request.
// - Mode bits 1:0 select response time and power, 00 fastest, 11 lowest.
// - Mode bit 7 is reserved, reads one; software always writes one.
// - Mode bits 3:2 read zero and ignore writes.
// - Comparator 0 mode bit 6 reads zero and ignores writes.
// - Comparator 0 mode register decodes at 0x9D on every page.
// - Control at 0x9A and comparator 1 mode at 0x9C only on page 0.
// - Control bit 7 enables comparator 1; zero holds it disabled, low power.
// - Edge flags set regardless of interrupt enables; enables gate only requests.
module comparator_mode_ctrl_regs
    import cmp_pkg::*;
(
    input  wire logic       MCLK_I,
    input  wire logic       RSTN_I,
    input  wire logic [7:0] SFR_ADDR_I,
    input  wire logic [7:0] SFR_PAGE_I,
    input  wire logic       SFR_WR_I,
    input  wire logic       SFR_RD_I,
    input  wire logic [7:0] SFR_WDATA_I,
    input  wire logic       CMP1_RESULT_I,
    input  wire logic       CMP0_RISE_FLAG_I,
    input  wire logic       CMP0_FALL_FLAG_I,
    output logic      [7:0] SFR_RDATA_O,
    output logic            CMP1_ON_O,
    output logic      [1:0] CMP1_POS_HYST_O,
    output logic      [1:0] CMP1_NEG_HYST_O,
    output logic      [1:0] CMP0_SPEED_POWER_SEL_O,
    output logic      [1:0] CMP1_SPEED_POWER_SEL_O,
    output logic            CMP0_IRQ_O,
    output logic            CMP1_IRQ_O
);

    // ======================================================================
    // Bus request and address decode.
    sfr_req_t   req;
    logic       sel_ctrl;
    logic       sel_mode1;
    logic       sel_mode0;

    // The paged registers answer only on page 0; comparator 0 mode ignores the page.
    always_comb begin
        req       = '{addr: SFR_ADDR_I, page: SFR_PAGE_I, wr: SFR_WR_I,
                      rd: SFR_RD_I, wdata: SFR_WDATA_I};
        sel_ctrl  = (req.addr == `CMP1_CTRL_ADDR) && (req.page == `CMP_SFR_PAGE);
        sel_mode1 = (req.addr == `CMP1_MODE_ADDR) && (req.page == `CMP_SFR_PAGE);
        sel_mode0 = (req.addr == `CMP0_MODE_ADDR);
    end

    // ======================================================================
    // Register state.
    ctrl_reg_t  ctrl_q;
    ctrl_reg_t  ctrl_d;
    mode_reg_t  mode0_q;
    mode_reg_t  mode0_d;
    mode_reg_t  mode1_q;
    mode_reg_t  mode1_d;
    logic       result_q;
    logic       rise_evt;
    logic       fall_evt;

    // The live result bit has no storage, so it is cut out of the reset word.
    localparam logic [7:0] ctrl_reset = `CTRL_RESET;

    // Edges are only taken while the comparator is on, since a disabled
    // comparator output is meaningless; flags ignore the interrupt enables.
    always_comb begin
        rise_evt = ctrl_q.cmp_on && CMP1_RESULT_I && !result_q;
        fall_evt = ctrl_q.cmp_on && !CMP1_RESULT_I && result_q;
    end

    // Writes store only implemented bits; an edge in the same cycle as a
    // clearing write wins so that no event is lost.
    always_comb begin
        ctrl_d  = ctrl_q;
        mode0_d = mode0_q;
        mode1_d = mode1_q;
        if (req.wr && sel_ctrl) begin
            ctrl_d.cmp_on    = req.wdata[`CTRL_ON_BIT];
            ctrl_d.rise_flag = req.wdata[`CTRL_RISE_BIT];
            ctrl_d.fall_flag = req.wdata[`CTRL_FALL_BIT];
            ctrl_d.pos_hyst  = req.wdata[`CTRL_PHYS_MSB:`CTRL_PHYS_LSB];
            ctrl_d.neg_hyst  = req.wdata[`CTRL_NHYS_MSB:`CTRL_NHYS_LSB];
        end
        if (rise_evt) begin
            ctrl_d.rise_flag = 1'b1;
        end
        if (fall_evt) begin
            ctrl_d.fall_flag = 1'b1;
        end
        if (req.wr && sel_mode0) begin
            mode0_d.rise_irq_en     = req.wdata[`MODE_RIE_BIT];
            mode0_d.fall_irq_en     = req.wdata[`MODE_FIE_BIT];
            mode0_d.speed_power_sel = req.wdata[`MODE_SEL_MSB:`MODE_SEL_LSB];
        end
        if (req.wr && sel_mode1) begin
            mode1_d.rise_irq_en     = req.wdata[`MODE_RIE_BIT];
            mode1_d.fall_irq_en     = req.wdata[`MODE_FIE_BIT];
            mode1_d.speed_power_sel = req.wdata[`MODE_SEL_MSB:`MODE_SEL_LSB];
        end
    end

    // Reset values; the result sample starts low and follows the input even while
    // the comparator is off, so an input already high at enabling is no rising edge.
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            ctrl_q   <= ctrl_reg_t'({ctrl_reset[`CTRL_ON_BIT],
                                     ctrl_reset[`CTRL_RISE_BIT:0]});
            mode0_q  <= '{1'b0, 1'b0, `MODE_SEL_RESET};
            mode1_q  <= '{1'b0, 1'b0, `MODE_SEL_RESET};
            result_q <= 1'b0;
        end else begin
            ctrl_q   <= ctrl_d;
            mode0_q  <= mode0_d;
            mode1_q  <= mode1_d;
            result_q <= CMP1_RESULT_I;
        end
    end

    // ======================================================================
    // Read path and interrupt requests.
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic       irq0_d;
    logic       irq1_d;
    logic       irq0_q;
    logic       irq1_q;

    // Reads return the state before any write in the same cycle; unmapped
    // addresses return zero.
    always_comb begin
        rdata_d = rdata_q;
        if (req.rd) begin
            rdata_d = 8'h00;
            if (sel_ctrl) begin
                rdata_d = {ctrl_q.cmp_on, result_q, ctrl_q.rise_flag,
                           ctrl_q.fall_flag, ctrl_q.pos_hyst, ctrl_q.neg_hyst};
            end else if (sel_mode1) begin
                rdata_d = {1'b1, 1'b0, mode1_q.rise_irq_en,
                           mode1_q.fall_irq_en, 2'b00, mode1_q.speed_power_sel};
            end else if (sel_mode0) begin
                rdata_d = {1'b1, 1'b0, mode0_q.rise_irq_en,
                           mode0_q.fall_irq_en, 2'b00, mode0_q.speed_power_sel};
            end
        end
        irq0_d = (mode0_q.rise_irq_en && CMP0_RISE_FLAG_I) ||
                 (mode0_q.fall_irq_en && CMP0_FALL_FLAG_I);
        irq1_d = (mode1_q.rise_irq_en && ctrl_q.rise_flag) ||
                 (mode1_q.fall_irq_en && ctrl_q.fall_flag);
    end

    // Requests lag the flags by one cycle so the output comes from a flop.
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            rdata_q <= 8'h00;
            irq0_q  <= 1'b0;
            irq1_q  <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            irq0_q  <= irq0_d;
            irq1_q  <= irq1_d;
        end
    end

    // Outputs to the analog comparators and the interrupt controller.
    always_comb begin
        SFR_RDATA_O            = rdata_q;
        CMP1_ON_O              = ctrl_q.cmp_on;
        CMP1_POS_HYST_O        = ctrl_q.pos_hyst;
        CMP1_NEG_HYST_O        = ctrl_q.neg_hyst;
        CMP0_SPEED_POWER_SEL_O = mode0_q.speed_power_sel;
        CMP1_SPEED_POWER_SEL_O = mode1_q.speed_power_sel;
        CMP0_IRQ_O             = irq0_q;
        CMP1_IRQ_O             = irq1_q;
    end

    // ======================================================================
    // Checks.
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);

    rise_flag_set_a: assert property (rise_evt |=> ctrl_q.rise_flag)
        else $error("Rising edge did not set the flag.");
    fall_flag_set_a: assert property (fall_evt |=> ctrl_q.fall_flag)
        else $error("Falling edge did not set the flag.");
    flag_sticky_a: assert property (ctrl_q.rise_flag && !(req.wr && sel_ctrl) |=>
        ctrl_q.rise_flag)
        else $error("Rising flag dropped without a write.");
    result_read_a: assert property (req.rd && sel_ctrl |=>
        SFR_RDATA_O[`CTRL_RESULT_BIT] == $past(result_q))
        else $error("Result bit read wrong.");
    mode_fixed_bits_a: assert property (req.rd && (sel_mode0 || sel_mode1) |=>
        SFR_RDATA_O[7:6] == 2'b10 && SFR_RDATA_O[3:2] == 2'b00)
        else $error("Mode register fixed bits read wrong.");
    // An edge in the same cycle may still set a flag, so such cycles are left out.
    page_gate_a: assert property (req.wr && req.addr == `CMP1_CTRL_ADDR &&
        req.page != `CMP_SFR_PAGE && !rise_evt && !fall_evt |=> $stable(ctrl_q))
        else $error("Control written off page 0.");
    hyst_write_a: assert property (req.wr && sel_ctrl |=>
        CMP1_POS_HYST_O == $past(req.wdata[3:2]) && CMP1_NEG_HYST_O == $past(req.wdata[1:0]))
        else $error("Hysteresis outputs not updated.");
    irq1_gate_a: assert property (!mode1_q.rise_irq_en && !mode1_q.fall_irq_en
        ##1 !mode1_q.rise_irq_en && !mode1_q.fall_irq_en |-> !CMP1_IRQ_O)
        else $error("Request without an enabled flag.");
    irq1_rise_a: assert property (mode1_q.rise_irq_en && ctrl_q.rise_flag |=>
        CMP1_IRQ_O)
        else $error("Enabled rising flag gave no request.");
    irq1_fall_a: assert property (mode1_q.fall_irq_en && ctrl_q.fall_flag |=>
        CMP1_IRQ_O)
        else $error("Enabled falling flag gave no request.");
    mode0_any_page_a: assert property (req.wr && req.addr == `CMP0_MODE_ADDR |=>
        CMP0_SPEED_POWER_SEL_O == $past(req.wdata[1:0]))
        else $error("Comparator 0 mode write missed.");

    rise_irq_c: cover property (rise_evt ##1 mode1_q.rise_irq_en ##1 CMP1_IRQ_O);
    clear_race_c: cover property (rise_evt && req.wr && sel_ctrl && !req.wdata[5]);
    fall_flag_c: cover property (fall_evt ##[1:20] (req.wr && sel_ctrl));
    mode0_read_c: cover property (req.rd && sel_mode0 && req.page != `CMP_SFR_PAGE);

endmodule

// ===== verilog/cmp_cfg.svh
`ifndef CMP_CFG_SVH
`define CMP_CFG_SVH

// ==========================================================================
// Register addresses and the page that gates the paged registers.
`define CMP1_CTRL_ADDR   8'h9A
`define CMP1_MODE_ADDR   8'h9C
`define CMP0_MODE_ADDR   8'h9D
`define CMP_SFR_PAGE     8'h00

// ==========================================================================
// Field positions of the comparator 1 control register.
`define CTRL_ON_BIT      7
`define CTRL_RESULT_BIT  6
`define CTRL_RISE_BIT    5
`define CTRL_FALL_BIT    4
`define CTRL_PHYS_MSB    3
`define CTRL_PHYS_LSB    2
`define CTRL_NHYS_MSB    1
`define CTRL_NHYS_LSB    0

// ==========================================================================
// Field positions of the mode registers.
`define MODE_RSVD_BIT    7
`define MODE_UNUSED_BIT  6
`define MODE_RIE_BIT     5
`define MODE_FIE_BIT     4
`define MODE_SEL_MSB     1
`define MODE_SEL_LSB     0

// ==========================================================================
// Reset values.
`define CTRL_RESET       8'h00
`define MODE_RESET       8'h82
`define MODE_SEL_RESET   2'h2

`endif

// ===== verilog/cmp_pkg.sv
// ==========================================================================
// Types shared by the comparator register block.
package cmp_pkg;

    // Stored state of one mode register; reserved and unused bits are not kept.
    typedef struct packed {
        logic       rise_irq_en;
        logic       fall_irq_en;
        logic [1:0] speed_power_sel;
    } mode_reg_t;

    // Stored state of the comparator 1 control register; the live result is not kept here.
    typedef struct packed {
        logic       cmp_on;
        logic       rise_flag;
        logic       fall_flag;
        logic [1:0] pos_hyst;
        logic [1:0] neg_hyst;
    } ctrl_reg_t;

    // One special-function-register bus request.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] page;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sfr_req_t;

endpackage

// ===== sim/sfr_host.sv
// ==========================================================================
// Bus master model standing in for the processor core.
module sfr_host
    import cmp_pkg::*;
(
    input  wire logic clk_i,
    output sfr_req_t  req_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus with no strobe at time zero.
    initial req_o = '{addr: 8'h00, page: 8'h00, wr: 1'b0, rd: 1'b0, wdata: 8'h00};

    // One strobe cycle, then the lines show inverted values so stale data never looks valid.
    task automatic acc(input logic [7:0] a, input logic [7:0] p, input logic w,
                       input logic [7:0] d);
        @(posedge clk_i);
        req_o <= '{addr: a, page: p, wr: w, rd: ~w, wdata: d};
        @(posedge clk_i);
        req_o <= '{addr: ~a, page: ~p, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
endmodule

// ===== sim/tb_comparator_mode_ctrl_regs.sv
// ==========================================================================
// Self-checking bench for the comparator register block.
module tb_comparator_mode_ctrl_regs
    import cmp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic       mclk    = 1'b0;
    logic       rstn    = 1'b0;
    logic       result  = 1'b0;
    logic       c0_rise = 1'b0;
    logic       c0_fall = 1'b0;
    sfr_req_t   req;
    logic [7:0] rdata;
    logic       on;
    logic [1:0] phys, nhys, sel0, sel1;
    logic       irq0, irq1;
    int         error_cnt   = 0;
    int         comparisons = 0;

    // A 100 ns period gives the 10 MHz system clock.
    always #50 mclk = ~mclk;

    sfr_host i_sfr_host (.clk_i(mclk), .req_o(req));

    comparator_mode_ctrl_regs i_comparator_mode_ctrl_regs (
        .MCLK_I(mclk), .RSTN_I(rstn), .SFR_ADDR_I(req.addr), .SFR_PAGE_I(req.page),
        .SFR_WR_I(req.wr), .SFR_RD_I(req.rd), .SFR_WDATA_I(req.wdata),
        .CMP1_RESULT_I(result), .CMP0_RISE_FLAG_I(c0_rise), .CMP0_FALL_FLAG_I(c0_fall),
        .SFR_RDATA_O(rdata), .CMP1_ON_O(on), .CMP1_POS_HYST_O(phys),
        .CMP1_NEG_HYST_O(nhys), .CMP0_SPEED_POWER_SEL_O(sel0),
        .CMP1_SPEED_POWER_SEL_O(sel1), .CMP0_IRQ_O(irq0), .CMP1_IRQ_O(irq1));

    // ======================================================================
    // Shared helpers.
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] p, input logic [7:0] exp);
        i_sfr_host.acc(a, p, 1'b0, 8'h00);
        @(negedge mclk);
        chk("read data", rdata, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_sfr_host.acc(a, 8'h00, 1'b1, d);
    endtask

    // Two edges cover the flag stage and the registered request stage.
    task automatic settle();
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask

    // ======================================================================
    // Scenarios.
    task automatic t_reset();
        rd_chk(8'h9D, 8'h05, 8'h82);
        rd_chk(8'h9C, 8'h00, 8'h82);
        rd_chk(8'h9A, 8'h00, 8'h00);
        chk("codes", {on, irq0, irq1, phys, nhys, 1'b0}, 8'h00);
        chk("modes", {4'h0, sel0, sel1}, 8'h0A);
    endtask

    // Bits 7:2 of every write in the loop are driven high so unused bits must be dropped.
    task automatic t_mode();
        for (int m = 0; m < 4; m++) begin
            wr(8'h9D, 8'hFC | 8'(m));
            wr(8'h9C, 8'hFC | 8'(m));
            @(negedge mclk);
            chk("mode sel", {4'h0, sel0, sel1}, 8'(m * 5));
            rd_chk(8'h9D, 8'h00, 8'hB0 | 8'(m));
            rd_chk(8'h9C, 8'h00, 8'hB0 | 8'(m));
        end
        wr(8'h9D, 8'h80);
        wr(8'h9C, 8'h80);
    endtask

    task automatic t_page();
        i_sfr_host.acc(8'h9A, 8'h01, 1'b1, 8'h8F);
        i_sfr_host.acc(8'h9C, 8'h01, 1'b1, 8'hB3);
        i_sfr_host.acc(8'h9D, 8'h0F, 1'b1, 8'h81);
        @(negedge mclk);
        chk("on off page", {7'h0, on}, 8'h00);
        rd_chk(8'h9A, 8'h01, 8'h00);
        rd_chk(8'h9C, 8'h00, 8'h80);
        rd_chk(8'h9D, 8'h00, 8'h81);
        rd_chk(8'h9B, 8'h00, 8'h00);
        wr(8'h9D, 8'h80);
    endtask

    task automatic t_hyst();
        for (int h = 0; h < 16; h++) begin
            wr(8'h9A, 8'h80 | 8'(h));
            @(negedge mclk);
            chk("hyst", {3'h0, on, phys, nhys}, 8'h10 | 8'(h));
        end
        rd_chk(8'h9A, 8'h00, 8'h8F);
        rd_chk(8'h9A, 8'h01, 8'h00);
        wr(8'h9A, 8'h00);
        @(negedge mclk);
        chk("on", {7'h0, on}, 8'h00);
    endtask

    task automatic t_edges();
        @(posedge mclk);
        result <= 1'b1;
        settle();
        rd_chk(8'h9A, 8'h00, 8'h40);
        @(posedge mclk);
        result <= 1'b0;
        settle();
        wr(8'h9A, 8'h80);
        wr(8'h9C, 8'hA0);
        result <= 1'b1;
        settle();
        chk("irq1 rise", {7'h0, irq1}, 8'h01);
        rd_chk(8'h9A, 8'h00, 8'hE0);
        wr(8'h9A, 8'h80);
        rd_chk(8'h9A, 8'h00, 8'hC0);
        chk("irq1 clear", {7'h0, irq1}, 8'h00);
        @(posedge mclk);
        result <= 1'b0;
        settle();
        chk("irq1 masked", {7'h0, irq1}, 8'h00);
        rd_chk(8'h9A, 8'h00, 8'h90);
        wr(8'h9C, 8'h90);
        settle();
        chk("irq1 fall", {7'h0, irq1}, 8'h01);
        wr(8'h9A, 8'h00);
    endtask

    task automatic t_cmp0();
        wr(8'h9D, 8'hA2);
        c0_fall <= 1'b1;
        settle();
        chk("irq0 masked", {7'h0, irq0}, 8'h00);
        @(posedge mclk);
        c0_rise <= 1'b1;
        settle();
        chk("irq0 rise", {7'h0, irq0}, 8'h01);
        wr(8'h9D, 8'h92);
        settle();
        chk("irq0 fall", {7'h0, irq0}, 8'h01);
        wr(8'h9D, 8'h82);
        settle();
        chk("irq0 off", {7'h0, irq0}, 8'h00);
    endtask

    // ======================================================================
    // Verdict and run control; the watchdog shares the same ending.
    task automatic conclude();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        t_reset();
        t_mode();
        t_page();
        t_hyst();
        t_edges();
        t_cmp0();
        // A second reset in mid-run must bring back every reset value.
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        t_reset();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        conclude();
    end
endmodule
